/* rtl/arp_ip_access_entry_matcher.sv */
`timescale 1ns/1ns
// Summary of operation
// - Destination address set to any: destination address of frame is ignored.
// - Destination host: frame destination must equal configured address exactly.
// - Destination network: compare only bits selected by destination mask.
// - Opcode class picks any, ARP, RARP, or neither ARP nor RARP.
// - Request/reply setting: any, request opcodes only, or reply opcodes only.
// - Sender address: any, host exact, or network under sender mask.
// - Target address: any, host exact, or network under target mask.
// - ARP check: 0 sender hw differs from source MAC, 1 equals, any off.
// - RARP check 0: target hw address must differ from source MAC.
// - RARP check 1: target hw equals source MAC; any disables it.
// - Length check on hw length 0x06 with protocol length 0x04: 1, 0, any.
// - Hardware space equal to 1: setting 1 requires, 0 forbids, any ignores.
// - Protocol space equal to 0x800: setting 1 requires, 0 forbids, any ignores.
module arp_ip_access_entry_matcher #(
   parameter int CNT_W = 16
) (
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        frame_valid,
   input  wire logic [31:0] dest_proto_addr,
   input  wire logic [31:0] sender_proto_addr,
   input  wire logic [31:0] target_proto_addr,
   input  wire logic [15:0] arp_opcode,
   input  wire logic [47:0] sender_hw_addr,
   input  wire logic [47:0] target_hw_addr,
   input  wire logic [47:0] frame_source_mac,
   input  wire logic [7:0]  hw_addr_len,
   input  wire logic [7:0]  proto_addr_len,
   input  wire logic [15:0] hw_space,
   input  wire logic [15:0] proto_space,
   output logic             match_valid,
   output logic             match_hit
);

   // ----------------------------------------
   // Register state
   // ----------------------------------------
   logic [31:0]      cfg_ff [access_entry_pkg::NUM_CFG_WORDS];
   logic [31:0]      ctrl_ff;
   logic             pready_ff;
   logic             pslverr_ff;
   logic [31:0]      prdata_ff;
   logic             match_valid_ff;
   logic             match_hit_ff;
   logic             seen_ff;
   logic [CNT_W-1:0] hit_cnt_ff;

   logic [31:0]      nxt_prdata;
   logic             nxt_pslverr;
   logic             wr_fire;
   logic             acc_first;
   logic [31:0]      frame_addrs [access_entry_pkg::NUM_ADDR_FILT];
   logic [2:0]       addr_ok;
   logic             is_arp;
   logic             is_rarp;
   logic             is_req;
   logic             is_reply;
   logic             opcls_ok;
   logic             rr_ok;
   logic             all_ok;

   access_entry_pkg::opcls_t opcls;
   access_entry_pkg::rr_t    rr_sel;
   access_entry_pkg::tri_t   arp_mac;
   access_entry_pkg::tri_t   rarp_mac;
   access_entry_pkg::tri_t   len_sel;
   access_entry_pkg::tri_t   hw_sel;
   access_entry_pkg::tri_t   pr_sel;

   assign opcls     = access_entry_pkg::opcls_t'(ctrl_ff[access_entry_pkg::CTRL_OPCLS_POS +: 2]);
   assign rr_sel    = access_entry_pkg::rr_t'(ctrl_ff[access_entry_pkg::CTRL_RR_POS +: 2]);
   assign arp_mac   = access_entry_pkg::tri_t'(ctrl_ff[access_entry_pkg::CTRL_ARP_MAC_POS +: 2]);
   assign rarp_mac  = access_entry_pkg::tri_t'(ctrl_ff[access_entry_pkg::CTRL_RARP_MAC_POS +: 2]);
   assign len_sel   = access_entry_pkg::tri_t'(ctrl_ff[access_entry_pkg::CTRL_LEN_POS +: 2]);
   assign hw_sel    = access_entry_pkg::tri_t'(ctrl_ff[access_entry_pkg::CTRL_HW_SPACE_POS +: 2]);
   assign pr_sel    = access_entry_pkg::tri_t'(ctrl_ff[access_entry_pkg::CTRL_PR_SPACE_POS +: 2]);

   // ----------------------------------------
   // APB slave
   // ----------------------------------------
   // One wait state: pready comes from a flop, so read data is ready with it
   assign acc_first = psel & penable & ~pready_ff;
   assign wr_fire   = psel & penable & pready_ff & pwrite;

   // Read mux and decode error
   always_comb begin
      nxt_prdata  = 32'h0000_0000;
      nxt_pslverr = 1'b0;
      if (paddr[1:0] != 2'b00) begin
         nxt_pslverr = 1'b1;
      end else if (paddr < access_entry_pkg::OFS_CTRL) begin
         nxt_prdata = cfg_ff[paddr[4:2]];
      end else if (paddr == access_entry_pkg::OFS_CTRL) begin
         nxt_prdata = ctrl_ff;
      end else if (paddr == access_entry_pkg::OFS_STATUS) begin
         nxt_prdata = {hit_cnt_ff, 14'h0000, seen_ff, match_hit_ff};
         nxt_pslverr = pwrite;  // Status is read-only
      end else begin
         nxt_pslverr = 1'b1;
      end
   end

   // Bus answer flops
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end else begin
         pready_ff  <= acc_first;
         pslverr_ff <= acc_first & nxt_pslverr;
         if (acc_first && !pwrite) begin
            prdata_ff <= nxt_prdata;
         end
      end
   end

   // Configuration writes; errored accesses leave state untouched
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         ctrl_ff <= access_entry_pkg::CTRL_RESET;
         for (int k = 0; k < access_entry_pkg::NUM_CFG_WORDS; k++) begin
            cfg_ff[k] <= access_entry_pkg::CFG_RESET;
         end
      end else if (wr_fire && !pslverr_ff) begin
         if (paddr == access_entry_pkg::OFS_CTRL) begin
            ctrl_ff <= pwdata;
         end else if (paddr < access_entry_pkg::OFS_CTRL) begin
            cfg_ff[paddr[4:2]] <= pwdata;
         end
      end
   end

   assign prdata  = prdata_ff;
   assign pready  = pready_ff;
   assign pslverr = pslverr_ff;

   // ----------------------------------------
   // Address filters
   // ----------------------------------------
   assign frame_addrs[0] = dest_proto_addr;
   assign frame_addrs[1] = sender_proto_addr;
   assign frame_addrs[2] = target_proto_addr;

   for (genvar i = 0; i < access_entry_pkg::NUM_ADDR_FILT; i++) begin : g_filt
      addr_cmp_if cmp_bus ();
      assign cmp_bus.mode       = access_entry_pkg::addr_mode_t'(ctrl_ff[2*i +: 2]);
      assign cmp_bus.cfg_addr   = cfg_ff[2*i];
      assign cmp_bus.cfg_mask   = cfg_ff[2*i+1];
      assign cmp_bus.frame_addr = frame_addrs[i];
      assign addr_ok[i]         = cmp_bus.ok;
      addr_cond_cmp u_cmp (
         .port (cmp_bus.cmp)
      );
   end

   // ----------------------------------------
   // Opcode and header checks
   // ----------------------------------------
   function automatic logic tri_ok(access_entry_pkg::tri_t sel, logic cond);
      return !sel[1] || (sel[0] == cond);
   endfunction

   assign is_arp   = (arp_opcode == access_entry_pkg::OP_ARP_REQ) ||
                     (arp_opcode == access_entry_pkg::OP_ARP_REPLY);
   assign is_rarp  = (arp_opcode == access_entry_pkg::OP_RARP_REQ) ||
                     (arp_opcode == access_entry_pkg::OP_RARP_REPLY);
   assign is_req   = (arp_opcode == access_entry_pkg::OP_ARP_REQ) ||
                     (arp_opcode == access_entry_pkg::OP_RARP_REQ);
   assign is_reply = (arp_opcode == access_entry_pkg::OP_ARP_REPLY) ||
                     (arp_opcode == access_entry_pkg::OP_RARP_REPLY);

   // Opcode class
   always_comb begin
      case (opcls)
         access_entry_pkg::OPC_ARP:   opcls_ok = is_arp;
         access_entry_pkg::OPC_RARP:  opcls_ok = is_rarp;
         access_entry_pkg::OPC_OTHER: opcls_ok = !is_arp && !is_rarp;
         default:                     opcls_ok = 1'b1;
      endcase
   end

   // Request or reply; code 3 treated as any
   always_comb begin
      case (rr_sel)
         access_entry_pkg::RR_REQ:   rr_ok = is_req;
         access_entry_pkg::RR_REPLY: rr_ok = is_reply;
         default:                    rr_ok = 1'b1;
      endcase
   end

   // Every enabled condition at once
   assign all_ok = (&addr_ok) & opcls_ok & rr_ok
      & tri_ok(arp_mac, sender_hw_addr == frame_source_mac)
      & tri_ok(rarp_mac, target_hw_addr == frame_source_mac)
      & tri_ok(len_sel, (hw_addr_len == access_entry_pkg::HW_LEN_ETH) &&
                        (proto_addr_len == access_entry_pkg::PR_LEN_IPV4))
      & tri_ok(hw_sel, hw_space == access_entry_pkg::HW_SPACE_ETH)
      & tri_ok(pr_sel, proto_space == access_entry_pkg::PR_SPACE_IP);

   // ----------------------------------------
   // Result and status
   // ----------------------------------------
   // Registered so the forwarding path sees a clean flop boundary
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         match_valid_ff <= 1'b0;
         match_hit_ff   <= 1'b0;
      end else begin
         match_valid_ff <= frame_valid;
         if (frame_valid) begin
            match_hit_ff <= all_ok;
         end
      end
   end

   // Hit counter wraps; software compares two reads
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         seen_ff    <= 1'b0;
         hit_cnt_ff <= '0;
      end else if (frame_valid) begin
         seen_ff <= 1'b1;
         if (all_ok) begin
            hit_cnt_ff <= hit_cnt_ff + 1'b1;
         end
      end
   end

   assign match_valid = match_valid_ff;
   assign match_hit   = match_hit_ff;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   dest_any_a: assert property (@(posedge mclk) disable iff (!nrst)
      frame_valid && ctrl_ff == 32'h0000_0000 |=> match_valid_ff && match_hit_ff)
      else $error("all-any entry did not match");
   dest_host_a: assert property (@(posedge mclk) disable iff (!nrst)
      frame_valid && ctrl_ff[1:0] == 2'b01 && dest_proto_addr != cfg_ff[0] |=> !match_hit_ff)
      else $error("destination host mismatch matched");
   dest_net_a: assert property (@(posedge mclk) disable iff (!nrst)
      frame_valid && ctrl_ff[1:0] == 2'b10 && ((dest_proto_addr ^ cfg_ff[0]) & cfg_ff[1]) != 0
      |=> !match_hit_ff)
      else $error("destination network mismatch matched");
   opcode_class_a: assert property (@(posedge mclk) disable iff (!nrst)
      frame_valid && opcls == access_entry_pkg::OPC_ARP && !is_arp |=> !match_hit_ff)
      else $error("non-ARP opcode matched ARP class");
   req_reply_a: assert property (@(posedge mclk) disable iff (!nrst)
      frame_valid && rr_sel == access_entry_pkg::RR_REPLY && is_req |=> !match_hit_ff)
      else $error("request matched reply setting");
   sender_host_a: assert property (@(posedge mclk) disable iff (!nrst)
      frame_valid && ctrl_ff[3:2] == 2'b01 && sender_proto_addr != cfg_ff[2] |=> !match_hit_ff)
      else $error("sender host mismatch matched");
   target_net_a: assert property (@(posedge mclk) disable iff (!nrst)
      frame_valid && ctrl_ff[5:4] == 2'b10 && ((target_proto_addr ^ cfg_ff[4]) & cfg_ff[5]) != 0
      |=> !match_hit_ff)
      else $error("target network mismatch matched");
   arp_mac_a: assert property (@(posedge mclk) disable iff (!nrst)
      frame_valid && arp_mac == access_entry_pkg::TRI_TRUE && sender_hw_addr != frame_source_mac
      |=> !match_hit_ff)
      else $error("ARP source MAC check failed");
   rarp_mac_a: assert property (@(posedge mclk) disable iff (!nrst)
      frame_valid && rarp_mac == access_entry_pkg::TRI_FALSE && target_hw_addr == frame_source_mac
      |=> !match_hit_ff)
      else $error("RARP source MAC check failed");
   len_check_a: assert property (@(posedge mclk) disable iff (!nrst)
      frame_valid && len_sel == access_entry_pkg::TRI_FALSE && hw_addr_len == 8'h06
      && proto_addr_len == 8'h04 |=> !match_hit_ff)
      else $error("forbidden length pair matched");
   proto_space_a: assert property (@(posedge mclk) disable iff (!nrst)
      frame_valid && pr_sel == access_entry_pkg::TRI_TRUE && proto_space != 16'h0800
      |=> !match_hit_ff)
      else $error("protocol space check failed");
   apb_answer_a: assert property (@(posedge mclk) disable iff (!nrst)
      psel && !penable ##1 psel && penable |-> !pready_ff ##1 pready_ff)
      else $error("APB answer not after one wait state");

   hit_c:     cover property (@(posedge mclk) disable iff (!nrst) frame_valid ##1 match_hit_ff);
   miss_c:    cover property (@(posedge mclk) disable iff (!nrst) frame_valid ##1 !match_hit_ff);
   wr_ctrl_c: cover property (@(posedge mclk) disable iff (!nrst)
      wr_fire && paddr == access_entry_pkg::OFS_CTRL);

endmodule

/* rtl/access_entry_pkg.sv */
package access_entry_pkg;

   // ----------------------------------------
   // Widths and bus map
   // ----------------------------------------
   localparam int         PROTO_ADDR_W   = 32;
   localparam int         HW_ADDR_W      = 48;
   localparam int         APB_ADDR_W     = 8;
   localparam int         NUM_ADDR_FILT  = 3;     // Destination, sender, target
   localparam int         NUM_CFG_WORDS  = 6;     // Address and mask per filter

   localparam logic [7:0] OFS_DEST_ADDR   = 8'h00;
   localparam logic [7:0] OFS_DEST_MASK   = 8'h04;
   localparam logic [7:0] OFS_SENDER_ADDR = 8'h08;
   localparam logic [7:0] OFS_SENDER_MASK = 8'h0c;
   localparam logic [7:0] OFS_TARGET_ADDR = 8'h10;
   localparam logic [7:0] OFS_TARGET_MASK = 8'h14;
   localparam logic [7:0] OFS_CTRL        = 8'h18;
   localparam logic [7:0] OFS_STATUS      = 8'h1c;

   localparam logic [31:0] CFG_RESET  = 32'h0000_0000;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;  // Every condition set to any

   // ----------------------------------------
   // Control field positions, two bits each
   // ----------------------------------------
   localparam int CTRL_DEST_POS      = 0;
   localparam int CTRL_SENDER_POS    = 2;
   localparam int CTRL_TARGET_POS    = 4;
   localparam int CTRL_OPCLS_POS     = 6;
   localparam int CTRL_RR_POS        = 8;
   localparam int CTRL_ARP_MAC_POS   = 10;
   localparam int CTRL_RARP_MAC_POS  = 12;
   localparam int CTRL_LEN_POS       = 14;
   localparam int CTRL_HW_SPACE_POS  = 16;
   localparam int CTRL_PR_SPACE_POS  = 18;

   // Status fields
   localparam int STAT_MATCH_POS = 0;
   localparam int STAT_SEEN_POS  = 1;
   localparam int STAT_CNT_POS   = 16;

   // ----------------------------------------
   // Setting encodings
   // ----------------------------------------
   typedef enum logic [1:0] {
      ADDR_ANY  = 2'b00,
      ADDR_HOST = 2'b01,
      ADDR_NET  = 2'b10
   } addr_mode_t;

   typedef enum logic [1:0] {
      OPC_ANY   = 2'b00,
      OPC_ARP   = 2'b01,
      OPC_RARP  = 2'b10,
      OPC_OTHER = 2'b11
   } opcls_t;

   typedef enum logic [1:0] {
      RR_ANY   = 2'b00,
      RR_REQ   = 2'b01,
      RR_REPLY = 2'b10
   } rr_t;

   typedef enum logic [1:0] {
      TRI_ANY   = 2'b00,
      TRI_FALSE = 2'b10,
      TRI_TRUE  = 2'b11
   } tri_t;

   // ----------------------------------------
   // Frame field constants
   // ----------------------------------------
   localparam logic [15:0] OP_ARP_REQ    = 16'h0001;
   localparam logic [15:0] OP_ARP_REPLY  = 16'h0002;
   localparam logic [15:0] OP_RARP_REQ   = 16'h0003;
   localparam logic [15:0] OP_RARP_REPLY = 16'h0004;
   localparam logic [7:0]  HW_LEN_ETH    = 8'h06;
   localparam logic [7:0]  PR_LEN_IPV4   = 8'h04;
   localparam logic [15:0] HW_SPACE_ETH  = 16'h0001;
   localparam logic [15:0] PR_SPACE_IP   = 16'h0800;

endpackage

/* rtl/addr_cmp_if.sv */
`timescale 1ns/1ns
interface addr_cmp_if;
   access_entry_pkg::addr_mode_t mode;
   logic [31:0]                  cfg_addr;
   logic [31:0]                  cfg_mask;
   logic [31:0]                  frame_addr;
   logic                         ok;

   modport ctl (output mode, output cfg_addr, output cfg_mask, output frame_addr, input ok);
   modport cmp (input mode, input cfg_addr, input cfg_mask, input frame_addr, output ok);
endinterface

/* rtl/addr_cond_cmp.sv */
`timescale 1ns/1ns
module addr_cond_cmp (
   addr_cmp_if.cmp port
);

   // ----------------------------------------
   // Any, host or masked network compare
   // ----------------------------------------
   // Unused mode code falls back to any, so a bad write never blocks traffic
   always_comb begin
      case (port.mode)
         access_entry_pkg::ADDR_HOST: begin
            port.ok = (port.frame_addr == port.cfg_addr);
         end
         access_entry_pkg::ADDR_NET: begin
            port.ok = (((port.frame_addr ^ port.cfg_addr) & port.cfg_mask) == 32'h0000_0000);
         end
         default: begin
            port.ok = 1'b1;
         end
      endcase
   end

endmodule

/* test/frame_feeder.sv */
`timescale 1ns/1ns
// Switch-side model: turns a one-cycle request into a parsed frame
module frame_feeder (
   input  wire logic         mclk,
   input  wire logic         req,
   input  wire logic [303:0] fields,
   output logic              frame_valid,
   output logic [303:0]      frame_bus
);
   // ----------------------------------------
   // Launch
   // ----------------------------------------
   // Fields go inverted between frames so stale values never look valid
   always_ff @(posedge mclk) begin
      frame_valid <= req;
      frame_bus   <= req ? fields : ~fields;
   end
endmodule

/* test/tb_arp_ip_access_entry_matcher.sv */
`timescale 1ns/1ns
module tb_arp_ip_access_entry_matcher;
   typedef struct packed {
      logic [31:0] dst;
      logic [31:0] snd;
      logic [31:0] tgt;
      logic [15:0] op;
      logic [47:0] sha;
      logic [47:0] tha;
      logic [47:0] src_mac;
      logic [7:0]  hlen;
      logic [7:0]  plen;
      logic [15:0] hws;
      logic [15:0] prs;
   } frame_t;

   logic          mclk;
   logic          nrst;
   logic          psel;
   logic          penable;
   logic          pwrite;
   logic [7:0]    paddr;
   logic [31:0]   pwdata;
   logic [31:0]   prdata;
   logic          pready;
   logic          pslverr;
   logic          frame_valid;
   logic          match_valid;
   logic          match_hit;
   logic          req;
   frame_t        fr;
   frame_t        fo;
   logic [303:0]  bus;
   int            miscompares = 0;
   int            n_tests = 0;
   int            hits = 0;
   int            cycles = 0;
   logic [31:0]   cfg [6] = '{32'h0a00_0001, 32'hffff_ff00, 32'hc0a8_0101,
                              32'hffff_0000, 32'hc0a8_01fe, 32'hffff_ff00};
   logic [31:0]   near_a [3] = '{32'h0a00_00ff, 32'hc0a8_ffff, 32'hc0a8_0101};
   logic [31:0]   far_a [3] = '{32'h0a00_0101, 32'hc0a9_0101, 32'hc0a8_02fe};

   assign fo = bus;

   frame_feeder frame_feeder_i (.mclk(mclk), .req(req), .fields(fr),
      .frame_valid(frame_valid), .frame_bus(bus));

   arp_ip_access_entry_matcher #(.CNT_W(16)) arp_ip_access_entry_matcher_i (
      .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .frame_valid(frame_valid), .dest_proto_addr(fo.dst),
      .sender_proto_addr(fo.snd), .target_proto_addr(fo.tgt), .arp_opcode(fo.op),
      .sender_hw_addr(fo.sha), .target_hw_addr(fo.tha), .frame_source_mac(fo.src_mac),
      .hw_addr_len(fo.hlen), .proto_addr_len(fo.plen), .hw_space(fo.hws),
      .proto_space(fo.prs), .match_valid(match_valid), .match_hit(match_hit));

   // ----------------------------------------
   // Clock and watchdog
   // ----------------------------------------
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   // A hung handshake ends here rather than running forever
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         report_and_stop();
      end
   end

   // ----------------------------------------
   // Compare and bus tasks
   // ----------------------------------------
   task automatic chk_word(input string nm, input logic [31:0] x, input logic [31:0] g);
      n_tests++;
      if (g !== x) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, x, g);
      end
   endtask

   task automatic chk_bit(input string nm, input logic x, input logic g);
      n_tests++;
      if (g !== x) begin
         miscompares++;
         $display("BAD %s expected %b seen %b", nm, x, g);
      end
   endtask

   // Holds the request until pready is sampled, then idles one edge
   // Only the watchdog ends a wait; the slave answers at the second access edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      chk_bit("pready wait", 1'b1, n == 2);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
      chk_bit("write error", 1'b0, e);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk_bit("read error", xe, e);
      chk_word("read data", x, r);
   endtask

   // Result is sampled two edges after the feeder launches the frame
   task automatic send(input frame_t f, input logic x);
      fr <= f;
      req <= 1'b1;
      @(posedge mclk);
      req <= 1'b0;
      repeat (2) @(posedge mclk);
      chk_bit("match_valid", 1'b1, match_valid);
      chk_bit("match_hit", x, match_hit);
      @(posedge mclk);
      chk_bit("match_valid drop", 1'b0, match_valid);
      if (x) hits++;
   endtask

   task automatic run(input logic [31:0] ctrl, input frame_t f, input logic x);
      wr(access_entry_pkg::OFS_CTRL, ctrl);
      send(f, x);
   endtask

   function automatic frame_t set_addr(frame_t f, int k, logic [31:0] v);
      if (k == 0) f.dst = v;
      else if (k == 1) f.snd = v;
      else f.tgt = v;
      return f;
   endfunction

   task automatic report_and_stop();
      if (miscompares == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      frame_t      f0;
      frame_t      f;
      logic [31:0] r;
      logic        e;
      logic [1:0]  code;
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      req = 1'b0;
      fr = '0;
      f0 = '{32'h0a00_0001, 32'hc0a8_0101, 32'hc0a8_01fe, 16'h0001, 48'h0200_0000_0001,
             48'h0200_0000_0002, 48'h0200_0000_0001, 8'h06, 8'h04, 16'h0001, 16'h0800};
      repeat (16) @(posedge mclk);
      nrst <= 1'b1;
      repeat (2) @(posedge mclk);
      // Reset values, then address and mask registers
      for (int i = 0; i < 8; i++) rd_chk(8'(4 * i), 32'h0, 1'b0);
      for (int i = 0; i < 6; i++) begin
         wr(8'(4 * i), cfg[i]);
         rd_chk(8'(4 * i), cfg[i], 1'b0);
      end
      run(32'h0, ~f0, 1'b1);
      // Host needs every bit; network ignores unmasked bits
      for (int k = 0; k < 3; k++) begin
         f = set_addr(f0, k, near_a[k]);
         run(32'h1 << (2 * k), f0, 1'b1);
         run(32'h1 << (2 * k), f, 1'b0);
         run(32'h2 << (2 * k), f, 1'b1);
         run(32'h2 << (2 * k), set_addr(f0, k, far_a[k]), 1'b0);
      end
      for (int c = 0; c < 4; c++) for (int o = 0; o < 6; o++) begin
         f = f0;
         f.op = 16'(o);
         run(32'(c) << 6, f, c == 0 || (c == 1 && (o == 1 || o == 2)) ||
             (c == 2 && (o == 3 || o == 4)) || (c == 3 && (o == 0 || o == 5)));
      end
      for (int q = 0; q < 3; q++) for (int o = 0; o < 6; o++) begin
         f = f0;
         f.op = 16'(o);
         run(32'(q) << 8, f, q == 0 || (q == 1 && (o == 1 || o == 3)) ||
             (q == 2 && (o == 2 || o == 4)));
      end
      // Each two-state check in any, must-be-false and must-be-true settings
      for (int t = 0; t < 5; t++) for (int s = 0; s < 3; s++) for (int v = 0; v < 2; v++) begin
         f = f0;
         if (t == 0 && v == 0) f.sha = ~f0.src_mac;
         if (t == 1 && v == 1) f.tha = f0.src_mac;
         if (t == 2 && v == 0) f.plen = 8'h08;
         if (t == 3 && v == 0) f.hws = 16'h0006;
         if (t == 4 && v == 0) f.prs = 16'h86dd;
         code = (s == 0) ? 2'b00 : (s == 1) ? 2'b10 : 2'b11;
         run(32'(code) << (10 + 2 * t), f, s == 0 || ((s == 2) == (v == 1)));
      end
      f = f0;
      f.op = 16'h0003;
      run(32'h0000_0c41, f0, 1'b1);
      run(32'h0000_0c41, f, 1'b0);
      // Back-to-back frames under the same settings
      f = set_addr(f0, 0, 32'h0a00_0002);
      fr <= f0;
      req <= 1'b1;
      @(posedge mclk);
      fr <= f;
      @(posedge mclk);
      req <= 1'b0;
      @(posedge mclk);
      chk_bit("first hit", 1'b1, match_hit);
      @(posedge mclk);
      chk_bit("second valid", 1'b1, match_valid);
      chk_bit("second hit", 1'b0, match_hit);
      hits++;
      // Refused accesses leave state alone
      rd_chk(8'h20, 32'h0, 1'b1);
      rd_chk(8'h02, 32'h0, 1'b1);
      apb(1'b1, 8'h19, 32'hffff_ffff, r, e);
      chk_bit("misaligned write error", 1'b1, e);
      apb(1'b1, access_entry_pkg::OFS_STATUS, 32'hffff_ffff, r, e);
      chk_bit("status write error", 1'b1, e);
      rd_chk(access_entry_pkg::OFS_CTRL, 32'h0000_0c41, 1'b0);
      rd_chk(access_entry_pkg::OFS_STATUS, {16'(hits), 14'h0, 1'b1, 1'b0}, 1'b0);
      report_and_stop();
   end
endmodule
